// *** common/sfp_pkg.sv ***
// shared constants and carrier types of the frame payload builder
package sfp_pkg;

  // ********************************************************************
  // nibble and frame timing, in link ticks
  // ********************************************************************
  localparam logic [11:0] NIBBLE_LOW_INTERVAL = 12'h005;
  localparam logic [11:0] NIBBLE_BASE_TICKS   = 12'h00C;
  localparam logic [11:0] SYNC_TICKS          = 12'h038;
  localparam logic [11:0] MIN_PAUSE_TICKS     = 12'h00C;

  // ********************************************************************
  // checksum
  // ********************************************************************
  localparam logic [3:0] CRC_SEED = 4'h5;
  localparam logic [3:0] CRC_POLY = 4'hD;

  // ********************************************************************
  // payload layout
  // ********************************************************************
  localparam logic [1:0] LAYOUT_MAG   = 2'h0;
  localparam logic [1:0] LAYOUT_DIAG  = 2'h1;
  localparam logic [1:0] LAYOUT_COUNT = 2'h2;
  localparam logic [1:0] LAYOUT_TEMP  = 2'h3;
  localparam logic [2:0] DATA_NIB_SHORT = 3'h3;
  localparam logic [2:0] DATA_NIB_LONG  = 3'h6;
  localparam int         FRAME_NIBS     = 8;
  localparam logic [11:0] COUNT_MAX_DIAG  = 12'h00F;
  localparam logic [11:0] COUNT_MAX_COUNT = 12'hFFF;

  // ********************************************************************
  // short serial message
  // ********************************************************************
  localparam logic [3:0] SS_LAST_FRAME = 4'hF;
  localparam logic [3:0] SS_ID_ERROR   = 4'h0;
  localparam logic [3:0] SS_ID_TEMP    = 4'h1;
  localparam logic [3:0] SS_ID_CID_LO  = 4'h2;
  localparam logic [3:0] SS_ID_CID_MID = 4'h3;
  localparam logic [3:0] SS_ID_CID_HI  = 4'h4;
  localparam logic [3:0] SS_ID_LAST    = 4'h4;

  // ********************************************************************
  // temperature scaling: value / 8 + 25, rounded
  // ********************************************************************
  localparam int                 TEMP_FRAC_BITS = 3;
  localparam logic signed [13:0] TEMP_ROUND     = 14'sh0004;
  localparam logic signed [13:0] TEMP_OFFSET    = 14'sh0019;
  localparam logic signed [13:0] TEMP_SAT_HI    = 14'sh007F;
  localparam logic signed [13:0] TEMP_SAT_LO    = -14'sh0080;
  localparam logic [7:0]         TEMP8_MAX      = 8'h7F;
  localparam logic [7:0]         TEMP8_MIN      = 8'h80;

  // ********************************************************************
  // carriers
  // ********************************************************************
  typedef struct packed {
    logic [1:0] dataLayout;
    logic       slowSerialDis;
    logic       sharedMode;
    logic       addrInStatus;
    logic       crcIncludesStatus;
  } sfp_cfg_t;

  typedef struct packed {
    logic [11:0] magOut;
    logic [11:0] tempOut;
    logic [7:0]  diagFlags;
    logic [7:0]  errStatus;
    logic [1:0]  devStatus;
  } sfp_sample_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_SYNC  = 4'b0010,
    ST_NIB   = 4'b0100,
    ST_PAUSE = 4'b1000
  } sfp_state_t;

endpackage

// *** rtl/sfp_crc4_step.sv ***
// one nibble step of the 4-bit checksum
`timescale 1ns/100ps
`default_nettype none

module sfp_crc4_step (
  input  wire logic [3:0] crcIn,
  input  wire logic [3:0] nibble,
  input  wire logic       enable,
  output logic      [3:0] crcOut
);

  logic [3:0] acc;
  logic       fb;

  // bits enter msb first; a disabled step passes the value through
  always_comb begin
    acc = crcIn;
    fb  = 1'b0;
    for (int i = 3; i >= 0; i--) begin
      fb  = acc[3] ^ nibble[i];
      acc = {acc[2:0], 1'b0} ^ (fb ? sfp_pkg::CRC_POLY : 4'h0);
    end
    crcOut = enable ? acc : crcIn;
  end

endmodule

`default_nettype wire

// *** rtl/sfp_frame_builder.sv ***
// frame payload builder: status, data, checksum and nibble timing of outgoing frames
//
// Behaviour
// - serial message only while slow serial disable is 0
// - message ids 0 to 4 from reset, wrap
// - sixteen frames per message, bit 3 start marker
// - bit 2 sends id, data, crc
// - message checksum over id and data, same algorithm
// - id 0 carries eight error status bits
// - id 1 carries rounded saturated 8-bit temperature
// - ids 2,3,4 carry customer identifier bytes
// - shared modes may put line address in bits 3:2
// - layout setting selects data nibbles
// - magnetic value first, nibbles msb first
// - frame counter wraps at 15 or 4095
// - temperature payload twelve-bit signed eighth degrees
// - diagnostic byte flags in fixed order
// - frame crc over data, seed 0101
// - shared modes may include status in crc
// - every nibble starts with five low ticks
// - sync, status, data, crc, then pause
// - status bits 1:0 carry device status
// - nibble lasts 12 to 27 ticks
`timescale 1ns/100ps
`default_nettype none

module sfp_frame_builder #(
  parameter int TICK_W = 12
) (
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic                tickEn,
  input  wire logic                frameReq,
  input  wire sfp_pkg::sfp_cfg_t   cfg,
  input  wire sfp_pkg::sfp_sample_t sample,
  input  wire logic [23:0]         customerIdentifier,
  input  wire logic [1:0]          lineAddr,
  input  wire logic [TICK_W-1:0]   pauseTicks,
  output logic                     sentLow,
  output logic                     busy,
  output logic                     frameDone,
  output logic [3:0]               statusNibble,
  output logic [11:0]              frameCount,
  output logic [3:0]               msgId
);

  // ********************************************************************
  // state
  // ********************************************************************
  sfp_pkg::sfp_state_t state;
  logic [TICK_W-1:0]   tickCnt;
  logic [2:0]          nibIdx;
  logic [2:0]          lastIdx;
  logic [3:0]          frameNib [sfp_pkg::FRAME_NIBS];
  logic [3:0]          ssIdx;
  logic [15:0]         ssWord;

  logic [TICK_W-1:0]   segLen;
  logic [TICK_W-1:0]   pauseLen;
  logic                segEnd;
  logic                startFrame;
  logic [3:0]          curNib;

  // ********************************************************************
  // payload assembly
  // ********************************************************************
  logic [3:0]  pNib [7];
  logic [2:0]  dataCnt;
  logic [11:0] extra;
  logic [3:0]  nextStatus;
  logic        serialOn;
  logic        inclStatus;

  assign serialOn   = !cfg.slowSerialDis;
  assign inclStatus = cfg.sharedMode && cfg.crcIncludesStatus;

  always_comb begin
    unique case (cfg.dataLayout)
      sfp_pkg::LAYOUT_DIAG:  extra = {sample.diagFlags, frameCount[3:0]};
      sfp_pkg::LAYOUT_COUNT: extra = frameCount;
      sfp_pkg::LAYOUT_TEMP:  extra = sample.tempOut;
      default:               extra = 12'h000;
    endcase
    dataCnt = (cfg.dataLayout == sfp_pkg::LAYOUT_MAG) ?
              sfp_pkg::DATA_NIB_SHORT : sfp_pkg::DATA_NIB_LONG;
  end

  // ********************************************************************
  // short serial message word
  // ********************************************************************
  logic signed [13:0] tRound;
  logic signed [13:0] tDeg;
  logic [7:0]         temp8;
  logic [7:0]         ssData;
  logic [3:0]         ssCrc [4];
  logic [15:0]        ssWordNow;
  logic               ssBit;

  // round away the fraction, then shift to ambient degrees and clamp
  always_comb begin
    tRound = (signed'({{2{sample.tempOut[11]}}, sample.tempOut}) + sfp_pkg::TEMP_ROUND)
             >>> sfp_pkg::TEMP_FRAC_BITS;
    tDeg   = tRound + sfp_pkg::TEMP_OFFSET;
    if (tDeg > sfp_pkg::TEMP_SAT_HI) begin
      temp8 = sfp_pkg::TEMP8_MAX;
    end else if (tDeg < sfp_pkg::TEMP_SAT_LO) begin
      temp8 = sfp_pkg::TEMP8_MIN;
    end else begin
      temp8 = tDeg[7:0];
    end
  end

  always_comb begin
    unique case (msgId)
      sfp_pkg::SS_ID_ERROR:   ssData = sample.errStatus;
      sfp_pkg::SS_ID_TEMP:    ssData = temp8;
      sfp_pkg::SS_ID_CID_LO:  ssData = customerIdentifier[7:0];
      sfp_pkg::SS_ID_CID_MID: ssData = customerIdentifier[15:8];
      sfp_pkg::SS_ID_CID_HI:  ssData = customerIdentifier[23:16];
      default:                ssData = 8'h00;
    endcase
  end

  assign ssCrc[0] = sfp_pkg::CRC_SEED;

  sfp_crc4_step ssStep0 (
    .crcIn  (ssCrc[0]),
    .nibble (msgId),
    .enable (1'b1),
    .crcOut (ssCrc[1])
  );

  sfp_crc4_step ssStep1 (
    .crcIn  (ssCrc[1]),
    .nibble (ssData[7:4]),
    .enable (1'b1),
    .crcOut (ssCrc[2])
  );

  sfp_crc4_step ssStep2 (
    .crcIn  (ssCrc[2]),
    .nibble (ssData[3:0]),
    .enable (1'b1),
    .crcOut (ssCrc[3])
  );

  assign ssWordNow = {msgId, ssData, ssCrc[3]};

  // the first frame uses the fresh word; later frames read the held copy
  assign ssBit = (ssIdx == 4'h0) ? ssWordNow[15] : ssWord[4'hF - ssIdx];

  always_comb begin
    nextStatus[1:0] = sample.devStatus;
    if (serialOn) begin
      nextStatus[3] = (ssIdx == 4'h0);
      nextStatus[2] = ssBit;
    end else if (cfg.sharedMode && cfg.addrInStatus) begin
      nextStatus[3:2] = lineAddr;
    end else begin
      nextStatus[3:2] = 2'h0;
    end
  end

  // ********************************************************************
  // frame checksum chain
  // ********************************************************************
  logic [3:0] crcChain [8];
  logic [6:0] stepEn;

  always_comb begin
    pNib[0] = nextStatus;
    pNib[1] = sample.magOut[11:8];
    pNib[2] = sample.magOut[7:4];
    pNib[3] = sample.magOut[3:0];
    pNib[4] = extra[11:8];
    pNib[5] = extra[7:4];
    pNib[6] = extra[3:0];
    stepEn[0] = inclStatus;
    for (int i = 1; i < 7; i++) begin
      stepEn[i] = (3'(i) <= dataCnt);
    end
  end

  assign crcChain[0] = sfp_pkg::CRC_SEED;

  for (genvar g = 0; g < 7; g++) begin : gCrc
    sfp_crc4_step step (
      .crcIn  (crcChain[g]),
      .nibble (pNib[g]),
      .enable (stepEn[g]),
      .crcOut (crcChain[g+1])
    );
  end

  // ********************************************************************
  // segment timing
  // ********************************************************************
  assign curNib   = frameNib[nibIdx];
  assign pauseLen = (pauseTicks < sfp_pkg::MIN_PAUSE_TICKS) ?
                    TICK_W'(sfp_pkg::MIN_PAUSE_TICKS) : pauseTicks;

  always_comb begin
    case (state)
      sfp_pkg::ST_SYNC:  segLen = TICK_W'(sfp_pkg::SYNC_TICKS);
      sfp_pkg::ST_NIB:   segLen = TICK_W'(sfp_pkg::NIBBLE_BASE_TICKS) + TICK_W'(curNib);
      sfp_pkg::ST_PAUSE: segLen = pauseLen;
      default:           segLen = TICK_W'(sfp_pkg::NIBBLE_BASE_TICKS);
    endcase
  end

  assign segEnd     = tickEn && (tickCnt == segLen - TICK_W'(1));
  assign startFrame = frameReq && ((state == sfp_pkg::ST_IDLE) ||
                                   ((state == sfp_pkg::ST_PAUSE) && segEnd));

  // ********************************************************************
  // frame sequencer
  // ********************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state  <= sfp_pkg::ST_IDLE;
      nibIdx <= 3'h0;
    end else begin
      case (state)
        sfp_pkg::ST_IDLE: begin
          if (startFrame) begin
            state <= sfp_pkg::ST_SYNC;
          end
        end
        sfp_pkg::ST_SYNC: begin
          if (segEnd) begin
            state  <= sfp_pkg::ST_NIB;
            nibIdx <= 3'h0;
          end
        end
        sfp_pkg::ST_NIB: begin
          if (segEnd) begin
            if (nibIdx == lastIdx) begin
              state <= sfp_pkg::ST_PAUSE;
            end else begin
              nibIdx <= nibIdx + 3'h1;
            end
          end
        end
        sfp_pkg::ST_PAUSE: begin
          if (segEnd) begin
            state <= startFrame ? sfp_pkg::ST_SYNC : sfp_pkg::ST_IDLE;
          end
        end
        default: state <= sfp_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tickCnt <= '0;
    end else if (startFrame || segEnd) begin
      tickCnt <= '0;
    end else if (tickEn && (state != sfp_pkg::ST_IDLE)) begin
      tickCnt <= tickCnt + TICK_W'(1);
    end
  end

  // one clock of lag against the tick counter, uniform over the frame
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sentLow <= 1'b0;
    end else begin
      sentLow <= (state != sfp_pkg::ST_IDLE) && (tickCnt < sfp_pkg::NIBBLE_LOW_INTERVAL);
    end
  end

  assign busy = (state != sfp_pkg::ST_IDLE);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      frameDone <= 1'b0;
    end else begin
      frameDone <= (state == sfp_pkg::ST_PAUSE) && segEnd;
    end
  end

  // ********************************************************************
  // frame latch
  // ********************************************************************
  // the whole frame is frozen at its start so a changing sample cannot
  // tear a frame between data and checksum
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < sfp_pkg::FRAME_NIBS; i++) begin
        frameNib[i] <= 4'h0;
      end
      lastIdx      <= sfp_pkg::DATA_NIB_SHORT + 3'h1;
      statusNibble <= 4'h0;
    end else if (startFrame) begin
      for (int i = 0; i < sfp_pkg::FRAME_NIBS; i++) begin
        if (i < 7 && 3'(i) <= dataCnt) begin
          frameNib[i] <= pNib[i];
        end else if (3'(i) == dataCnt + 3'h1) begin
          frameNib[i] <= crcChain[7];
        end else begin
          frameNib[i] <= 4'h0;
        end
      end
      lastIdx      <= dataCnt + 3'h1;
      statusNibble <= nextStatus;
    end
  end

  // ********************************************************************
  // frame counter
  // ********************************************************************
  // counted as a frame is taken, so a frame latches the value from before its own step
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      frameCount <= 12'h000;
    end else if (startFrame) begin
      if (cfg.dataLayout == sfp_pkg::LAYOUT_DIAG &&
          frameCount >= sfp_pkg::COUNT_MAX_DIAG) begin
        frameCount <= 12'h000;
      end else if (frameCount == sfp_pkg::COUNT_MAX_COUNT) begin
        frameCount <= 12'h000;
      end else begin
        frameCount <= frameCount + 12'h001;
      end
    end
  end

  // ********************************************************************
  // short serial message sequencing
  // ********************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ssWord <= 16'h0000;
    end else if (startFrame && serialOn && ssIdx == 4'h0) begin
      ssWord <= ssWordNow;
    end
  end

  // disabling the stream abandons the message in flight; the id is kept
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ssIdx <= 4'h0;
      msgId <= sfp_pkg::SS_ID_ERROR;
    end else if (!serialOn) begin
      ssIdx <= 4'h0;
    end else if (startFrame) begin
      ssIdx <= ssIdx + 4'h1;
      if (ssIdx == sfp_pkg::SS_LAST_FRAME) begin
        msgId <= (msgId == sfp_pkg::SS_ID_LAST) ? sfp_pkg::SS_ID_ERROR
                                                 : msgId + 4'h1;
      end
    end
  end

endmodule

`default_nettype wire

// *** tb/sfp_frame_builder_assertions.sv ***
// concurrent port checks of the frame payload builder
`timescale 1ns/100ps
`default_nettype none

module sfp_frame_builder_chk #(
  parameter int TICK_W = 12
) (
  input wire logic                 clk,
  input wire logic                 nrst,
  input wire logic                 tickEn,
  input wire logic                 frameReq,
  input wire sfp_pkg::sfp_cfg_t    cfg,
  input wire sfp_pkg::sfp_sample_t sample,
  input wire logic [23:0]          customerIdentifier,
  input wire logic [1:0]           lineAddr,
  input wire logic [TICK_W-1:0]    pauseTicks,
  input wire logic                 sentLow,
  input wire logic                 busy,
  input wire logic                 frameDone,
  input wire logic [3:0]           statusNibble,
  input wire logic [11:0]          frameCount,
  input wire logic [3:0]           msgId
);
  logic       tickD;
  logic [3:0] lowTicks;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // ticks counted one clock late, as the line lags the tick counter
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tickD    <= 1'h0;
      lowTicks <= 4'h0;
    end else begin
      tickD <= tickEn;
      if (!sentLow) begin
        lowTicks <= 4'h0;
      end else if (tickD) begin
        lowTicks <= lowTicks + 4'h1;
      end
    end
  end

  sequence s_start;
    !busy ##1 busy;
  endsequence

  a_busy_after_req: assert property (!busy && frameReq |=> busy)
    else $error("frame request not taken");
  a_req_needed: assert property ($rose(busy) |-> $past(frameReq))
    else $error("frame started without request");
  a_done_pulse: assert property (frameDone |-> $past(busy) ##1 !frameDone)
    else $error("frame end pulse malformed");
  a_low_five: assert property ($fell(sentLow) |-> lowTicks == 4'h5)
    else $error("low interval not five ticks");
  a_count_step: assert property ($changed(frameCount) |-> frameCount ==
    (($past(frameCount) == 12'hFFF || ($past(cfg.dataLayout) == 2'h1 &&
    $past(frameCount) >= 12'h00F)) ? 12'h000 : $past(frameCount) + 12'h001))
    else $error("frame counter step wrong");
  a_msg_wrap: assert property ($changed(msgId) |-> msgId ==
    (($past(msgId) == 4'h4) ? 4'h0 : $past(msgId) + 4'h1))
    else $error("message id sequence wrong");
  a_status_dev: assert property (s_start |-> statusNibble[1:0] == $past(sample.devStatus))
    else $error("device status bits wrong");
  a_status_idle: assert property (s_start ##0 ($past(cfg.slowSerialDis) &&
    !$past(cfg.sharedMode && cfg.addrInStatus)) |-> statusNibble[3:2] == 2'h0)
    else $error("serial bits not cleared");
  a_status_addr: assert property (s_start ##0 $past(cfg.slowSerialDis &&
    cfg.sharedMode && cfg.addrInStatus) |-> statusNibble[3:2] == $past(lineAddr))
    else $error("line address not in status");
endmodule

bind sfp_frame_builder sfp_frame_builder_chk #(.TICK_W(TICK_W)) u_chk (
  .clk(clk), .nrst(nrst), .tickEn(tickEn), .frameReq(frameReq), .cfg(cfg),
  .sample(sample), .customerIdentifier(customerIdentifier), .lineAddr(lineAddr),
  .pauseTicks(pauseTicks), .sentLow(sentLow), .busy(busy), .frameDone(frameDone),
  .statusNibble(statusNibble), .frameCount(frameCount), .msgId(msgId)
);
`default_nettype wire

// *** tb/sfp_sent_rx.sv ***
// line receiver model: measures segments and decodes nibble values
`timescale 1ns/100ps
`default_nettype none

module sfp_sent_rx (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        tickEn,
  input  wire logic        sentLow,
  input  wire logic [3:0]  nNib,
  output logic      [31:0] nibs,
  output logic      [3:0]  nGot,
  output logic             bad
);
  logic        lowPrev;
  logic        tickD;
  logic [11:0] segTicks;
  logic [3:0]  lowTicks;

  // nGot of 9 means frame complete, so a pause is never taken for a nibble
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lowPrev  <= 1'h0;
      tickD    <= 1'h0;
      segTicks <= 12'h000;
      lowTicks <= 4'h0;
      nibs     <= 32'h0000_0000;
      nGot     <= 4'h9;
      bad      <= 1'h0;
    end else begin
      tickD   <= tickEn;
      lowPrev <= sentLow;
      if (sentLow && !lowPrev) begin
        segTicks <= {11'h000, tickD};
        lowTicks <= {3'h0, tickD};
        if (segTicks == 12'h038) begin
          nGot <= 4'h0;
          nibs <= 32'h0000_0000;
        end else if (nGot < nNib) begin
          bad  <= bad | (segTicks < 12'h00C) | (segTicks > 12'h01B);
          nibs <= {nibs[27:0], segTicks[3:0] - 4'hC};
          nGot <= (nGot + 4'h1 == nNib) ? 4'h9 : nGot + 4'h1;
        end
      end else begin
        segTicks <= segTicks + {11'h000, tickD};
        if (sentLow) begin
          lowTicks <= lowTicks + {3'h0, tickD};
        end
        if (!sentLow && lowPrev && lowTicks != 4'h5) begin
          bad <= 1'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// testbench of the frame payload builder against the line receiver model
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic                 clk;
  logic                 nrst;
  logic                 frameReq;
  logic                 tickEn;
  sfp_pkg::sfp_cfg_t    cfg;
  sfp_pkg::sfp_sample_t sample;
  logic [23:0]          customerIdentifier;
  logic [1:0]           lineAddr;
  logic [11:0]          pauseTicks;
  logic                 sentLow;
  logic                 busy;
  logic                 frameDone;
  logic [3:0]           statusNibble;
  logic [11:0]          frameCount;
  logic [3:0]           msgId;
  logic [3:0]           nNib;
  logic [31:0]          nibs;
  logic [3:0]           nGot;
  logic                 bad;
  logic [15:0]          word;
  logic [3:0]           expId;
  logic [11:0]          expCnt;
  int                   ssIdx;
  int                   errCount;
  int                   totalChecks;
  int                   i;
  logic [3:0]           shTbl [6] = '{4'h8, 4'hE, 4'hD, 4'hB, 4'h5, 4'h0};

  always #50 clk = ~clk;

  // one tick every second clock, so tick counts and clock counts differ
  always begin
    @(posedge clk);
    #10;
    tickEn = !tickEn;
  end

  sfp_frame_builder u_sfp_frame_builder (
    .clk(clk), .nrst(nrst), .tickEn(tickEn), .frameReq(frameReq), .cfg(cfg),
    .sample(sample), .customerIdentifier(customerIdentifier), .lineAddr(lineAddr),
    .pauseTicks(pauseTicks), .sentLow(sentLow), .busy(busy), .frameDone(frameDone),
    .statusNibble(statusNibble), .frameCount(frameCount), .msgId(msgId)
  );
  sfp_sent_rx u_sfp_sent_rx (
    .clk(clk), .nrst(nrst), .tickEn(tickEn), .sentLow(sentLow), .nNib(nNib),
    .nibs(nibs), .nGot(nGot), .bad(bad)
  );

  // ********************************************************************
  // helpers
  // ********************************************************************
  task automatic step;
    @(posedge clk);
    #10;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] want, input string what);
    totalChecks++;
    if (got !== want) begin
      errCount++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask

  function automatic logic [3:0] crcNib(input logic [3:0] c, input logic [3:0] n);
    logic [3:0] r;
    r = c;
    for (int b = 3; b >= 0; b--) begin
      r = {r[2:0], 1'h0} ^ ((r[3] ^ n[b]) ? 4'hD : 4'h0);
    end
    return r;
  endfunction

  function automatic logic [7:0] temp8(input logic [11:0] t);
    int v;
    v = (($signed({{20{t[11]}}, t}) + 4) >>> 3) + 25;
    if (v > 127) v = 127;
    if (v < -128) v = -128;
    return v[7:0];
  endfunction

  task automatic frame(input logic [1:0] lay, input logic dis, input logic [2:0] sh);
    logic [31:0] exp;
    logic [23:0] pay;
    logic [3:0]  st;
    logic [3:0]  crc;
    logic [7:0]  d;
    int          n;
    int          k;
    cfg = '{lay, dis, sh[2], sh[1], sh[0]};
    sample.magOut    = sample.magOut + 12'h3A7;
    sample.tempOut   = sample.tempOut ^ 12'hC03;
    sample.errStatus = sample.errStatus + 8'h1D;
    sample.diagFlags = ~sample.errStatus;
    sample.devStatus = sample.devStatus + 2'h1;
    if (dis) begin
      ssIdx = 0;
      st = {(sh[2] && sh[1]) ? lineAddr : 2'h0, sample.devStatus};
    end else begin
      if (ssIdx == 0) begin
        case (expId)
          4'h0: d = sample.errStatus;
          4'h1: d = temp8(sample.tempOut);
          default: d = customerIdentifier[8 * (int'(expId) - 2) +: 8];
        endcase
        word = {expId, d, crcNib(crcNib(crcNib(4'h5, expId), d[7:4]), d[3:0])};
      end
      st = {ssIdx == 0, word[15 - ssIdx], sample.devStatus};
    end
    case (lay)
      2'h0: pay = {12'h000, sample.magOut};
      2'h1: pay = {sample.magOut, sample.diagFlags, expCnt[3:0]};
      2'h2: pay = {sample.magOut, expCnt};
      default: pay = {sample.magOut, sample.tempOut};
    endcase
    n = (lay == 2'h0) ? 3 : 6;
    exp = {28'h000_0000, st};
    crc = (sh[2] && sh[0]) ? crcNib(4'h5, st) : 4'h5;
    for (k = n - 1; k >= 0; k--) begin
      exp = {exp[27:0], pay[4 * k +: 4]};
      crc = crcNib(crc, pay[4 * k +: 4]);
    end
    exp = {exp[27:0], crc};
    nNib = 4'(n + 2);
    frameReq = 1'h1;
    k = 0;
    do begin
      step;
      k++;
    end while (busy !== 1'h1 && k < 9);
    chk(32'(busy), 32'h0000_0001, "frame taken");
    frameReq = 1'h0;
    k = 0;
    while (frameDone !== 1'h1 && k < 4000) begin
      step;
      k++;
    end
    if (k >= 4000) begin
      errCount++;
      $display("wrong value at %0t: frame never ended", $time);
      results;
    end
    if (!dis) begin
      ssIdx++;
      if (ssIdx == 16) begin
        ssIdx = 0;
        expId = (expId == 4'h4) ? 4'h0 : expId + 4'h1;
      end
    end
    expCnt = ((lay == 2'h1 && expCnt >= 12'h00F) || expCnt == 12'hFFF) ? 12'h000 : expCnt + 12'h001;
    chk(nibs, exp, "nibbles");
    chk(32'(nGot), 32'h0000_0009, "frame end");
    chk(32'(statusNibble), 32'(st), "status");
    chk(32'(frameCount), 32'(expCnt), "counter");
    chk(32'(msgId), 32'(expId), "message id");
    chk(32'(bad), 32'h0000_0000, "line timing");
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ********************************************************************
  // main sequence
  // ********************************************************************
  initial begin
    clk = 1'h0;
    nrst = 1'h0;
    frameReq = 1'h0;
    tickEn = 1'h0;
    cfg = '0;
    sample = '{12'h5A1, 12'h3F5, 8'h00, 8'h96, 2'h0};
    customerIdentifier = 24'hC3_81E4;
    lineAddr = 2'h2;
    pauseTicks = 12'h014;
    nNib = 4'h5;
    word = 16'h0000;
    expId = 4'h0;
    expCnt = 12'h000;
    ssIdx = 0;
    errCount = 0;
    totalChecks = 0;
    repeat (3) step;
    nrst = 1'h1;
    // five whole messages and a wrap, layouts changing every seven frames
    for (i = 0; i < 84; i++) frame(2'(i / 7), 1'h0, 3'h0);
    // serial off mid-message, shared options, then serial back on
    for (i = 0; i < 6; i++) frame(2'(i), shTbl[i][3], shTbl[i][2:0]);
    // reset in mid-frame restarts message ids and the counter
    frameReq = 1'h1;
    repeat (40) step;
    nrst = 1'h0;
    frameReq = 1'h0;
    step;
    chk(32'({busy, sentLow, msgId, frameCount}), 32'h0000_0000, "reset state");
    nrst = 1'h1;
    ssIdx = 0;
    expId = 4'h0;
    expCnt = 12'h000;
    for (i = 0; i < 3; i++) frame(2'h2, 1'h0, 3'h0);
    results;
  end
endmodule
`default_nettype wire
